/* File: rcwd_pkg.sv */
/*
 * Shared constants for the radio configuration word decoder: word layout,
 * field positions, reset word, decode tables and pin bundle sizes.
 * Assumes nothing of its surroundings; every design file imports it whole.
 */
package rcwd_pkg;

    // ********************************************************************
    // Word layout
    // ********************************************************************
    localparam int CFG_W = 144;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CFG_BITS = 8'h90;
    localparam logic [CFG_W-1:0] CFG_RESET = 144'h8e08_1c20_2000_0000_00e7_0000_0000_e721_0f04;

    // Lowest bit of the retained protocol section.
    localparam int PROTO_LO = 16;
    localparam int LOOP_HI = 121;
    localparam int LOOP_LO = 120;
    localparam int PLEN2_HI = 119;
    localparam int PLEN2_LO = 112;
    localparam int PLEN1_HI = 111;
    localparam int PLEN1_LO = 104;
    localparam int KEY2_HI = 103;
    localparam int KEY2_LO = 64;
    localparam int KEY1_HI = 63;
    localparam int KEY1_LO = 24;
    localparam int KW_HI = 23;
    localparam int KW_LO = 18;
    localparam int CRCL_BIT = 17;
    localparam int CRCE_BIT = 16;
    localparam int DUAL_BIT = 15;
    localparam int PROTO_BIT = 14;
    localparam int RATE_BIT = 13;
    localparam int XO_HI = 12;
    localparam int XO_LO = 10;
    localparam int PWR_HI = 9;
    localparam int PWR_LO = 8;
    localparam int CH_HI = 7;
    localparam int CH_LO = 1;
    localparam int DIR_BIT = 0;
    localparam int KEY_W = 40;

    // ********************************************************************
    // Decode tables
    // ********************************************************************
    localparam logic [4:0] CRC_SHORT = 5'h08;
    localparam logic [4:0] CRC_LONG = 5'h10;
    localparam logic [3:0] PREAMBLE_BITS = 4'h8;
    localparam logic [9:0] RATE_SLOW_KBPS = 10'h0fa;
    localparam logic [9:0] RATE_FAST_KBPS = 10'h3e8;
    localparam logic [4:0] XO_4 = 5'h04;
    localparam logic [4:0] XO_8 = 5'h08;
    localparam logic [4:0] XO_12 = 5'h0c;
    localparam logic [4:0] XO_16 = 5'h10;
    localparam logic [4:0] XO_20 = 5'h14;
    localparam logic [4:0] XO_NONE = 5'h00;
    localparam logic signed [5:0] PWR_M20 = 6'h2c;
    localparam logic signed [5:0] PWR_M10 = 6'h36;
    localparam logic signed [5:0] PWR_M5 = 6'h3b;
    localparam logic signed [5:0] PWR_0 = 6'h00;
    localparam logic [11:0] BASE_MHZ = 12'h960;
    localparam logic [11:0] RX2_OFFSET_MHZ = 12'h008;
    localparam logic [8:0] PACKET_BITS = 9'h100;

    // ********************************************************************
    // Pin bundle
    // ********************************************************************
    localparam int PIN_W = 3;
    localparam int PIN_SEL = 2;
    localparam int PIN_SCK = 1;
    localparam int PIN_DAT = 0;

endpackage

/* File: rcwd_pin_sync.sv */
/*
 * Two-stage synchroniser for the three serial configuration pins.
 * Assumes the pins are asynchronous to clk and change slowly against it.
 */
`timescale 1ns/1ns
module rcwd_pin_sync
    import rcwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [PIN_W-1:0] pin_raw,
    output logic [PIN_W-1:0] pin_sync
);

    // ********************************************************************
    // Synchroniser stages
    // ********************************************************************
    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;

    // The first stage is read by the second stage only.
    genvar g;
    generate
        for (g = 0; g < PIN_W; g++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= pin_raw[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign pin_sync = sync_q;

endmodule

/* File: rcwd_field_decode.sv */
/*
 * Registered decoder that turns the held configuration word into settings.
 * Assumes cfg_word is a flop output on the same clock.
 */
`timescale 1ns/1ns
module rcwd_field_decode
    import rcwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [CFG_W-1:0] cfg_word,
    output logic tx_loop_closed,
    output logic rx_loop_closed,
    output logic [7:0] payload_len_second,
    output logic [7:0] payload_len_first,
    output logic [KEY_W-1:0] rx_match_key_second,
    output logic [KEY_W-1:0] rx_match_key_first,
    output logic [5:0] key_width,
    output logic [4:0] crc_bits,
    output logic crc_enable,
    output logic dual_receive_enable,
    output logic comm_protocol_select,
    output logic [3:0] preamble_bits,
    output logic [8:0] payload_budget,
    output logic [9:0] air_rate_kbps,
    output logic [4:0] crystal_mhz,
    output logic signed [5:0] tx_output_dbm,
    output logic [6:0] channel_number,
    output logic [11:0] tx_freq_mhz,
    output logic [11:0] rx1_freq_mhz,
    output logic [11:0] rx2_freq_mhz,
    output logic receive_direction
);

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [KEY_W-1:0] key_mask(input logic [KEY_W-1:0] key,
                                                  input logic [5:0] width);
        logic [KEY_W-1:0] m;
        m = '0;
        for (int i = 0; i < KEY_W; i++) begin
            m[i] = key[i] & (width > 6'(i));
        end
        return m;
    endfunction

    logic [5:0] kw;
    logic [4:0] crc_len;
    logic [11:0] f1;
    assign kw = cfg_word[KW_HI:KW_LO];
    assign crc_len = cfg_word[CRCL_BIT] ? CRC_LONG : CRC_SHORT;
    assign f1 = BASE_MHZ + {5'h00, cfg_word[CH_HI:CH_LO]};

    // ********************************************************************
    // Registered settings
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_loop_closed <= 1'b0;
            rx_loop_closed <= 1'b0;
            payload_len_second <= 8'h00;
            payload_len_first <= 8'h00;
            rx_match_key_second <= '0;
            rx_match_key_first <= '0;
            key_width <= 6'h00;
            crc_bits <= 5'h00;
            crc_enable <= 1'b0;
            dual_receive_enable <= 1'b0;
            comm_protocol_select <= 1'b0;
            preamble_bits <= 4'h0;
            payload_budget <= 9'h000;
            air_rate_kbps <= 10'h000;
            tx_output_dbm <= 6'h00;
            channel_number <= 7'h00;
            tx_freq_mhz <= 12'h000;
            rx1_freq_mhz <= 12'h000;
            rx2_freq_mhz <= 12'h000;
            receive_direction <= 1'b0;
        end else begin
            // high bit closes the transmit loop, low bit opens receive.
            tx_loop_closed <= cfg_word[LOOP_HI];
            rx_loop_closed <= ~cfg_word[LOOP_LO];
            payload_len_second <= cfg_word[PLEN2_HI:PLEN2_LO];
            payload_len_first <= cfg_word[PLEN1_HI:PLEN1_LO];
            // key bits above the width are dropped.
            rx_match_key_second <= key_mask(cfg_word[KEY2_HI:KEY2_LO], kw);
            rx_match_key_first <= key_mask(cfg_word[KEY1_HI:KEY1_LO], kw);
            key_width <= kw;
            crc_bits <= crc_len;
            crc_enable <= cfg_word[CRCE_BIT];
            dual_receive_enable <= cfg_word[DUAL_BIT];
            comm_protocol_select <= cfg_word[PROTO_BIT];
            // preamble only in packet mode, outside the budget.
            preamble_bits <= cfg_word[PROTO_BIT] ? PREAMBLE_BITS : 4'h0;
            payload_budget <= PACKET_BITS - {3'h0, kw} - {4'h0, crc_len};
            air_rate_kbps <= cfg_word[RATE_BIT] ? RATE_FAST_KBPS : RATE_SLOW_KBPS;
            unique case (cfg_word[PWR_HI:PWR_LO])
                2'h0: tx_output_dbm <= PWR_M20;
                2'h1: tx_output_dbm <= PWR_M10;
                2'h2: tx_output_dbm <= PWR_M5;
                2'h3: tx_output_dbm <= PWR_0;
            endcase
            channel_number <= cfg_word[CH_HI:CH_LO];
            tx_freq_mhz <= f1;
            rx1_freq_mhz <= f1;
            // second channel eight steps above the first.
            rx2_freq_mhz <= f1 + RX2_OFFSET_MHZ;
            receive_direction <= cfg_word[DIR_BIT];
        end
    end

    // crystal table; codes above four are not defined and read zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            crystal_mhz <= XO_NONE;
        end else begin
            case (cfg_word[XO_HI:XO_LO])
                3'h0: crystal_mhz <= XO_4;
                3'h1: crystal_mhz <= XO_8;
                3'h2: crystal_mhz <= XO_12;
                3'h3: crystal_mhz <= XO_16;
                3'h4: crystal_mhz <= XO_20;
                default: crystal_mhz <= XO_NONE;
            endcase
        end
    end

endmodule

/* File: rcwd_top.sv */
/*
 * Configuration word loader and decoder of a 2.4 GHz transceiver.
 * Assumes the three serial pins are asynchronous and the shift clock
 * is far slower than clk, so that each level lasts several clk cycles.
 */
//
// Contract
// - Protocol section bits 119..16 stay held while powered; reset only at power-up.
// - Loop field selects transmit and receive loop closure per code.
// - Two eight-bit payload widths, channel two upper, channel one lower.
// - Packet mode adds an 8-bit preamble outside the budget.
// - Two 40-bit receive keys at bits 103..64 and 63..24.
// - Key bits above configured width are ignored.
// - Checksum length bit selects 8 or 16 bits.
// - Checksum enable turns generation and checking on together.
// - Dual receive bit; second channel sits 8 channels higher.
// - Mode bit selects direct or automatic packet mode.
// - Rate bit selects 250 kbps or 1 Mbps; fast needs 16 MHz crystal. The code decodes the rate bit alone, with any crystal code.
// - Crystal codes 0..4 map to 4, 8, 12, 16, 20 MHz.
// - Power codes map to -20, -10, -5, 0 dBm.
// - Frequency is 2400 MHz plus channel; channel two adds 8.
// - Lowest bit selects transmit at 0, receive at 1.
// - Word enters MSB first, one bit per rising shift clock.
// - New word applies only when select falls.
// - Only as many bits as were shifted get updated.
`timescale 1ns/1ns
module rcwd_top
    import rcwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfg_select,
    input wire logic config_shift_clock,
    input wire logic cfg_data,
    output logic tx_loop_closed,
    output logic rx_loop_closed,
    output logic [7:0] payload_len_second,
    output logic [7:0] payload_len_first,
    output logic [KEY_W-1:0] rx_match_key_second,
    output logic [KEY_W-1:0] rx_match_key_first,
    output logic [5:0] key_width,
    output logic [4:0] crc_bits,
    output logic crc_enable,
    output logic dual_receive_enable,
    output logic comm_protocol_select,
    output logic [3:0] preamble_bits,
    output logic [8:0] payload_budget,
    output logic [9:0] air_rate_kbps,
    output logic [4:0] crystal_mhz,
    output logic signed [5:0] tx_output_dbm,
    output logic [6:0] channel_number,
    output logic [11:0] tx_freq_mhz,
    output logic [11:0] rx1_freq_mhz,
    output logic [11:0] rx2_freq_mhz,
    output logic receive_direction
);

    // ********************************************************************
    // Pin synchronisation and edge detection
    // ********************************************************************
    logic [PIN_W-1:0] pins_s;
    logic sel_s;
    logic sck_s;
    logic dat_s;
    logic sel_prev_q;
    logic sck_prev_q;
    logic sel_fall;
    logic sck_rise;

    rcwd_pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_raw({cfg_select, config_shift_clock, cfg_data}),
        .pin_sync(pins_s)
    );

    assign sel_s = pins_s[PIN_SEL];
    assign sck_s = pins_s[PIN_SCK];
    assign dat_s = pins_s[PIN_DAT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_s;
            sck_prev_q <= sck_s;
        end
    end

    assign sel_fall = sel_prev_q & ~sel_s;
    assign sck_rise = ~sck_prev_q & sck_s;

    // ********************************************************************
    // Shift register and bit count
    // ********************************************************************
    logic [CFG_W-1:0] shift_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    // MSB first, so the newest bit lands at bit 0.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_q <= '0;
        end else if (sel_s && sck_rise) begin
            shift_q <= {shift_q[CFG_W-2:0], dat_s};
        end
    end

    // The count saturates at a full word; extra bits only push old ones out.
    always_comb begin
        count_d = count_q;
        if (!sel_s) begin
            count_d = '0;
        end else if (sck_rise && count_q < CFG_BITS) begin
            count_d = count_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // ********************************************************************
    // Held configuration word
    // ********************************************************************
    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] cfg_d;

    // only the falling select applies shifted bits.
    // bits beyond the shifted count keep their value.
    // a short load lands on the lowest bits.
    always_comb begin
        cfg_d = cfg_q;
        for (int i = 0; i < CFG_W; i++) begin
            if (sel_fall && count_q > CNT_W'(i)) begin
                cfg_d[i] = shift_q[i];
            end
        end
    end

    // the word resets only at power-up and is otherwise kept.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ********************************************************************
    // Field decoder
    // ********************************************************************
    // both keys are taken from their fixed word positions.
    rcwd_field_decode u_dec (
        .clk(clk),
        .rst_n(rst_n),
        .cfg_word(cfg_q),
        .tx_loop_closed(tx_loop_closed),
        .rx_loop_closed(rx_loop_closed),
        .payload_len_second(payload_len_second),
        .payload_len_first(payload_len_first),
        .rx_match_key_second(rx_match_key_second),
        .rx_match_key_first(rx_match_key_first),
        .key_width(key_width),
        .crc_bits(crc_bits),
        .crc_enable(crc_enable),
        .dual_receive_enable(dual_receive_enable),
        .comm_protocol_select(comm_protocol_select),
        .preamble_bits(preamble_bits),
        .payload_budget(payload_budget),
        .air_rate_kbps(air_rate_kbps),
        .crystal_mhz(crystal_mhz),
        .tx_output_dbm(tx_output_dbm),
        .channel_number(channel_number),
        .tx_freq_mhz(tx_freq_mhz),
        .rx1_freq_mhz(rx1_freq_mhz),
        .rx2_freq_mhz(rx2_freq_mhz),
        .receive_direction(receive_direction)
    );

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence shift_edge_s;
        sel_s && sck_rise && count_q < CFG_BITS;
    endsequence

    sequence low_byte_load_s;
        sel_fall && count_q == 8'h08;
    endsequence

    sequence short_load_s;
        sel_fall && count_q < 8'h11;
    endsequence

    shift_count_a:
    assert property (shift_edge_s |=> count_q == $past(count_q) + 8'h01
                     && shift_q[0] == $past(dat_s))
        else $error("shift edge did not add one bit");

    shift_order_a:
    assert property (sel_s && sck_rise |=> shift_q[CFG_W-1:1] == $past(shift_q[CFG_W-2:0]))
        else $error("shift register did not move up by one");

    apply_edge_a:
    assert property (!sel_fall |=> cfg_q == $past(cfg_q))
        else $error("word changed without a falling select");

    low_byte_a:
    assert property (low_byte_load_s |=> cfg_q[CFG_W-1:8] == $past(cfg_q[CFG_W-1:8])
                     && cfg_q[7:0] == $past(shift_q[7:0]))
        else $error("low byte load touched wrong bits");

    proto_keep_a:
    assert property (short_load_s |=> cfg_q[CFG_W-1:PROTO_LO] == $past(cfg_q[CFG_W-1:PROTO_LO]))
        else $error("protocol section lost on a short load");

    full_load_a:
    assert property (sel_fall && count_q == CFG_BITS |=> cfg_q == $past(shift_q))
        else $error("full load did not take every bit");

    rx2_offset_a:
    assert property ($past(rst_n) |-> rx2_freq_mhz ==
                     BASE_MHZ + RX2_OFFSET_MHZ + {5'h00, $past(cfg_q[CH_HI:CH_LO])})
        else $error("second receive channel not eight above");

    freq_base_a:
    assert property ($past(rst_n) |-> tx_freq_mhz == BASE_MHZ + {5'h00, $past(cfg_q[CH_HI:CH_LO])})
        else $error("transmit frequency wrong");

    key_mask_a:
    assert property ($past(rst_n) && key_width < 6'h28 |->
                     (rx_match_key_first >> key_width) == '0)
        else $error("key bits above width not cleared");

    crc_len_a:
    assert property ($past(rst_n) |-> crc_bits == ($past(cfg_q[CRCL_BIT]) ? CRC_LONG : CRC_SHORT))
        else $error("checksum length wrong");

    preamble_a:
    assert property ($past(rst_n) |-> preamble_bits == ($past(cfg_q[PROTO_BIT]) ? 4'h8 : 4'h0))
        else $error("preamble not tied to packet mode");

    loop_a:
    assert property ($past(rst_n) |-> tx_loop_closed == $past(cfg_q[LOOP_HI])
                     && rx_loop_closed == !$past(cfg_q[LOOP_LO]))
        else $error("loop state decode wrong");

    direction_a:
    assert property ($past(rst_n) |-> receive_direction == $past(cfg_q[DIR_BIT]))
        else $error("direction bit not followed");

    rate_a:
    assert property ($past(rst_n) |-> air_rate_kbps ==
                     ($past(cfg_q[RATE_BIT]) ? RATE_FAST_KBPS : RATE_SLOW_KBPS))
        else $error("air rate decode wrong");

    power_a:
    assert property ($past(rst_n) && $past(cfg_q[PWR_HI:PWR_LO]) == 2'h0 |->
                     tx_output_dbm == PWR_M20)
        else $error("lowest power code wrong");

    crystal_a:
    assert property ($past(rst_n) && $past(cfg_q[XO_HI:XO_LO]) == 3'h4 |-> crystal_mhz == XO_20)
        else $error("crystal code four wrong");

    crc_on_a:
    assert property ($past(rst_n) |-> crc_enable == $past(cfg_q[CRCE_BIT]))
        else $error("checksum enable not followed");

    mode_a:
    assert property ($past(rst_n) |-> comm_protocol_select == $past(cfg_q[PROTO_BIT])
                     && dual_receive_enable == $past(cfg_q[DUAL_BIT]))
        else $error("mode bits not followed");

    width_a:
    assert property ($past(rst_n) |-> payload_len_second == $past(cfg_q[PLEN2_HI:PLEN2_LO])
                     && payload_len_first == $past(cfg_q[PLEN1_HI:PLEN1_LO]))
        else $error("payload widths wrong");

    count_clear_a:
    assert property (!sel_s |=> count_q == 8'h00)
        else $error("bit count not cleared while deselected");

    power_top_a:
    assert property ($past(rst_n) && $past(cfg_q[PWR_HI:PWR_LO]) == 2'h3 |->
                     tx_output_dbm == PWR_0)
        else $error("highest power code wrong");

    crystal_low_a:
    assert property ($past(rst_n) && $past(cfg_q[XO_HI:XO_LO]) == 3'h0 |-> crystal_mhz == XO_4)
        else $error("crystal code zero wrong");

    key_second_a:
    assert property ($past(rst_n) && key_width < 6'h28 |->
                     (rx_match_key_second >> key_width) == '0)
        else $error("second key bits above width not cleared");

endmodule

/* File: rcwd_host_model.sv */
/* Host model that loads the configuration word over the three serial pins.
   Assumes clk is the device clock; every pin changes on its falling edge. */
`timescale 1ns/1ns
module rcwd_host_model (
    input wire logic clk,
    output logic cfg_select,
    output logic config_shift_clock,
    output logic cfg_data
);
    // ****************************************
    // Serial load
    // ****************************************
    initial begin
        cfg_select = 1'b0;
        config_shift_clock = 1'b0;
        cfg_data = 1'b1;
    end

    // MSB first shifting
    // Each shift-clock level lasts four clk cycles, so the link runs at 80 ns.
    task automatic send(input logic [143:0] w, input int n);
        @(negedge clk) cfg_select = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            cfg_data = w[i];
            repeat (4) @(negedge clk);
            config_shift_clock = 1'b1;
            repeat (4) @(negedge clk);
            config_shift_clock = 1'b0;
        end
        repeat (4) @(negedge clk);
    endtask

    // A released data line shows the inverse of its last level, never a held value.
    task automatic release_sel();
        cfg_select = 1'b0;
        cfg_data = ~cfg_data;
    endtask
endmodule

/* File: tb_top.sv */
/* Self-checking bench for the configuration word decoder.
   Assumes the host model drives the pins and the word default of the package. */
`timescale 1ns/1ns
module tb_top
    import rcwd_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_select, config_shift_clock, cfg_data, tx_loop_closed, rx_loop_closed;
    logic crc_enable, dual_receive_enable, comm_protocol_select, receive_direction;
    logic [7:0] payload_len_second, payload_len_first;
    logic [KEY_W-1:0] rx_match_key_second, rx_match_key_first;
    logic [5:0] key_width;
    logic [4:0] crc_bits, crystal_mhz;
    logic [3:0] preamble_bits;
    logic [8:0] payload_budget;
    logic [9:0] air_rate_kbps;
    logic signed [5:0] tx_output_dbm;
    logic [6:0] channel_number;
    logic [11:0] tx_freq_mhz, rx1_freq_mhz, rx2_freq_mhz;
    logic [CFG_W-1:0] exp_w;
    int num_errors = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    rcwd_top dut_u (.clk, .rst_n, .cfg_select, .config_shift_clock, .cfg_data,
        .tx_loop_closed, .rx_loop_closed, .payload_len_second, .payload_len_first,
        .rx_match_key_second, .rx_match_key_first, .key_width, .crc_bits, .crc_enable,
        .dual_receive_enable, .comm_protocol_select, .preamble_bits, .payload_budget,
        .air_rate_kbps, .crystal_mhz, .tx_output_dbm, .channel_number, .tx_freq_mhz,
        .rx1_freq_mhz, .rx2_freq_mhz, .receive_direction);
    rcwd_host_model host_u (.clk, .cfg_select, .config_shift_clock, .cfg_data);

    // ****************************************
    // Checking
    // ****************************************
    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_all();
        logic [39:0] m;
        logic [4:0] crc;
        logic [2:0] xo;
        logic [11:0] f;
        m = (exp_w[23:18] >= 6'h28) ? '1 : (40'h1 << exp_w[23:18]) - 40'h1;
        crc = exp_w[17] ? 5'h10 : 5'h08;
        xo = exp_w[12:10];
        f = 12'h960 + {5'h0, exp_w[7:1]};
        check("tx_loop", tx_loop_closed, exp_w[121]);
        check("rx_loop", rx_loop_closed, !exp_w[120]);
        check("len2", payload_len_second, exp_w[119:112]);
        check("len1", payload_len_first, exp_w[111:104]);
        check("key2", rx_match_key_second, exp_w[103:64] & m);
        check("key1", rx_match_key_first, exp_w[63:24] & m);
        check("kw", key_width, exp_w[23:18]);
        check("crc", crc_bits, crc);
        check("crc_en", crc_enable, exp_w[16]);
        check("dual", dual_receive_enable, exp_w[15]);
        check("mode", comm_protocol_select, exp_w[14]);
        check("pre", preamble_bits, exp_w[14] ? 4'h8 : 4'h0);
        check("budget", payload_budget, 9'h100 - {3'h0, exp_w[23:18]} - {4'h0, crc});
        check("rate", air_rate_kbps, exp_w[13] ? 10'h3e8 : 10'h0fa);
        check("xo", crystal_mhz, (xo < 3'h5) ? {xo, 2'b00} + 5'h04 : 5'h00);
        check("dbm", {42'h0, tx_output_dbm}, exp_w[9] ? (exp_w[8] ? 6'h00 : 6'h3b)
            : (exp_w[8] ? 6'h36 : 6'h2c));
        check("chan", channel_number, exp_w[7:1]);
        check("txf", tx_freq_mhz, f);
        check("rx1f", rx1_freq_mhz, f);
        check("rx2f", rx2_freq_mhz, f + 12'h008);
        check("dir", receive_direction, exp_w[0]);
    endtask

    task automatic load(input logic [CFG_W-1:0] w, input int n);
        logic [CFG_W-1:0] m;
        m = '1;
        m = ~(m << n);
        host_u.send(w, n);
        check_all();
        host_u.release_sel();
        exp_w = (exp_w & ~m) | (w & m);
        repeat (8) @(negedge clk);
        check_all();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        exp_w = CFG_RESET;
        check_all();
    endtask

    // Key width 20 with ones above it; rate stays slow since the rate bit is clear, with crystal code four (20 MHz).
    task automatic test_full();
        load({24'h0, 8'hc8, 8'h37, 40'ha55aa55aa5, 40'hffffffffff, 6'h14, 5'h1e,
            3'h4, 2'h1, 7'h50, 1'b0}, 144);
    endtask

    // The loop field is loaded nonzero only here; code 3 from the last pass stays held through test_short.
    task automatic test_modes();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            load({22'h0, c, 8'h10, 8'h20, 80'h0, 6'h28, c[0], c[1], c[0], c[1], &c,
                1'b0, c, c, 7'h74, c[0]}, 122);
        end
    endtask

    task automatic test_short();
        load({136'h0, 7'h21, 1'b1}, 8);
        // Crystal code seven is undefined and must read as no crystal.
        load({128'h0, 16'h5e20}, 16);
        load('0, 0);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        test_reset();
        test_full();
        test_modes();
        test_short();
        complete_run();
    end

    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
endmodule
